// [design/jec_ctrl_vars.sv]
// JPEG encoder control variables and frame handshake sequencer
//
// Notes on behaviour
// - Format codes 0, 1, 2 select 4:2:2, 4:2:0, monochrome; reset 0.
// - Config bit 0 set means continuous video, clear means single snapshot.
// - Config bit 1 makes the device wait for the host after error frames.
// - Config bit 2 makes the device retry a failed frame.
// - Config bit 4 enables scaled quantization table generation.
// - Config bit 5 enables automatic quantization table choice.
// - Config bits 7:6 hold the table id in use; config resets to 52.
// - Restart interval zero disables restart markers; reset zero.
// - Scaling bytes carry 7-bit factors, bit 7 flags new value; resets 6, 9, 12.
// - Waiting for the host ends after a programmable frame count, reset 10.
// - Length bits 23:16 of the previous frame read from a byte.
// - Length bits 15:0 of the previous frame read from a word.
// - Width and height are read only, follow output size, reset 1600, 1200.
`timescale 1ns/1ps
module jec_ctrl_vars
   import jec_pkg::*;
#(
   parameter int ADDR_W  = 5,
   parameter int LIMIT_W = 8
) (
   input  wire logic              clk,          // System clock, 20 MHz
   input  wire logic              rst,          // Async reset, active high
   input  wire logic [ADDR_W-1:0] var_addr,     // Variable byte offset
   input  wire logic              var_wr,       // Write strobe
   input  wire logic              var_rd,       // Read strobe
   input  wire logic [7:0]        var_wdata,    // Write data
   output logic      [7:0]        var_rdata,    // Read data
   output logic                   var_rvalid,   // Read data valid pulse
   input  wire logic              capture_req,  // Snapshot request
   input  wire logic              frame_tick,   // Frame boundary pulse
   input  wire jec_enc_res_t      enc_res,      // Frame result from encoder
   input  wire logic [15:0]       out_width,    // Configured output width
   input  wire logic [15:0]       out_height,   // Configured output height
   input  wire logic [1:0]        auto_qtab_id, // Table chosen by auto select
   output jec_enc_ctl_t           enc_ctl       // Controls to the encoder
);
   import jec_pkg::*;

   initial begin
      if (ADDR_W < 5) begin
         $error("jec_ctrl_vars: ADDR_W must be at least 5");
      end
      if (LIMIT_W != 8) begin
         $error("jec_ctrl_vars: LIMIT_W must be 8");
      end
   end

   jec_regs_t s_q;
   jec_regs_t s_d;
   logic      tmr_expired;

   // Multi-byte variables are big endian: the MSB sits at the lower offset
   function automatic logic [7:0] read_byte(input jec_regs_t s,
                                            input logic [ADDR_W-1:0] a);
      logic [7:0] r;
      r = 8'h00;
      // Offsets beyond the bank's 32 bytes read as zero on a wider address bus
      if ((a >> 5) == '0) begin
         case (a[4:0])
            OFS_METHOD:          r = s.method[15:8];
            OFS_METHOD + 5'h01:  r = s.method[7:0];
            OFS_WIDTH:           r = s.width[15:8];
            OFS_WIDTH + 5'h01:   r = s.width[7:0];
            OFS_HEIGHT:          r = s.height[15:8];
            OFS_HEIGHT + 5'h01:  r = s.height[7:0];
            OFS_FORMAT:          r = s.format;
            OFS_CONFIG:          r = s.cfg;
            OFS_RESTART:         r = s.restart[15:8];
            OFS_RESTART + 5'h01: r = s.restart[7:0];
            OFS_QUANT_SCALE_FIRST:         r = s.qscale[0];
            OFS_QUANT_SCALE_SECOND:         r = s.qscale[1];
            OFS_QUANT_SCALE_THIRD:         r = s.qscale[2];
            OFS_WAIT_LIM:        r = s.wait_lim;
            OFS_STATE:           r = 8'(s.st);
            OFS_LEN_HI:          r = s.len[23:16];
            OFS_LEN_LO:          r = s.len[15:8];
            OFS_LEN_LO + 5'h01:  r = s.len[7:0];
            default:             r = 8'h00;
         endcase
      end
      return r;
   endfunction

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [4:0] ofs);
      return a == ADDR_W'(ofs);
   endfunction

   jec_frame_timer #(
      .LIMIT_W (LIMIT_W)
   ) u_timer (
      .clk     (clk),
      .rst     (rst),
      .arm     (s_q.arm),
      .stop    (s_q.st != JEC_WAIT),
      .tick    (frame_tick),
      .limit   (s_q.wait_lim),
      .expired (tmr_expired)
   );

   always_comb begin
      logic       wr_cfg;
      logic       resume;
      logic [7:0] cfg_w;
      wr_cfg = var_wr && hit(var_addr, OFS_CONFIG);
      resume = 1'b0;
      cfg_w  = s_q.cfg;
      s_d           = s_q;
      s_d.arm       = 1'b0;
      s_d.rvalid    = 1'b0;
      s_d.ctl.qload = 3'b000;
      s_d.ctl.retry = 1'b0;

      // Size readback tracks the datapath every cycle
      s_d.width  = out_width;
      s_d.height = out_height;

      // Frame boundary outside the host wait consumes new scaling factors
      if (frame_tick && s_q.st != JEC_WAIT) begin
         for (int i = 0; i < 3; i++) begin
            if (s_q.qscale[i][QS_NEW]) begin
               s_d.ctl.qload[i]      = 1'b1;
               s_d.ctl.qscale[i]     = s_q.qscale[i][QS_FACT_W-1:0];
               s_d.qscale[i][QS_NEW] = 1'b0;
            end
         end
      end

      // Sequencer
      case (s_q.st)
         JEC_IDLE: begin
            if (s_q.cfg[CFG_VIDEO] || capture_req) begin
               s_d.st = JEC_ENCODE;
            end
         end
         JEC_ENCODE: begin
            if (enc_res.done) begin
               s_d.len = enc_res.len;
               if (enc_res.ok) begin
                  if (!s_q.cfg[CFG_VIDEO]) begin
                     s_d.st = JEC_IDLE;
                  end
               end else if (s_q.cfg[CFG_HSHAKE]) begin
                  s_d.st              = JEC_WAIT;
                  s_d.arm             = 1'b1;
                  s_d.cfg[CFG_READY]  = 1'b0;
               end else begin
                  resume = 1'b1;
               end
            end
         end
         JEC_WAIT: begin
            if (s_q.cfg[CFG_READY]) begin
               s_d.cfg[CFG_READY] = 1'b0;
               resume             = 1'b1;
            end else if (tmr_expired) begin
               resume = 1'b1;
            end
         end
         default: begin
            s_d.st = JEC_IDLE;
         end
      endcase

      if (resume) begin
         if (s_q.cfg[CFG_RETRY]) begin
            s_d.ctl.retry = 1'b1;
            s_d.st        = JEC_ENCODE;
         end else if (s_q.cfg[CFG_VIDEO]) begin
            s_d.st = JEC_ENCODE;
         end else begin
            s_d.st = JEC_IDLE;
         end
      end

      // Auto select reports the table actually in use
      if (s_q.cfg[CFG_AUTO]) begin
         s_d.cfg[7:CFG_QID_LSB] = auto_qtab_id;
      end

      // Host writes come last so a set beats a same-cycle clear
      if (var_wr) begin
         if (hit(var_addr, OFS_METHOD)) begin
            s_d.method[15:8] = var_wdata;
         end
         if (hit(var_addr, OFS_METHOD + 5'h01)) begin
            s_d.method[7:0] = var_wdata;
         end
         if (hit(var_addr, OFS_FORMAT) && var_wdata <= FMT_MONO) begin
            s_d.format = var_wdata;
         end
         if (wr_cfg) begin
            cfg_w = var_wdata;
            if (s_q.cfg[CFG_AUTO] && var_wdata[CFG_AUTO]) begin
               cfg_w[7:CFG_QID_LSB] = s_d.cfg[7:CFG_QID_LSB];
            end
            s_d.cfg = cfg_w;
         end
         if (hit(var_addr, OFS_RESTART)) begin
            s_d.restart[15:8] = var_wdata;
         end
         if (hit(var_addr, OFS_RESTART + 5'h01)) begin
            s_d.restart[7:0] = var_wdata;
         end
         if (hit(var_addr, OFS_QUANT_SCALE_FIRST)) begin
            s_d.qscale[0] = var_wdata;
         end
         if (hit(var_addr, OFS_QUANT_SCALE_SECOND)) begin
            s_d.qscale[1] = var_wdata;
         end
         if (hit(var_addr, OFS_QUANT_SCALE_THIRD)) begin
            s_d.qscale[2] = var_wdata;
         end
         if (hit(var_addr, OFS_WAIT_LIM)) begin
            s_d.wait_lim = var_wdata;
         end
      end

      if (var_rd) begin
         s_d.rdata  = read_byte(s_q, var_addr);
         s_d.rvalid = 1'b1;
      end

      // Encoder controls follow the next register values
      s_d.ctl.run         = (s_d.st == JEC_ENCODE);
      s_d.ctl.host_wait   = (s_d.st == JEC_WAIT);
      s_d.ctl.format      = s_d.format[1:0];
      s_d.ctl.video       = s_d.cfg[CFG_VIDEO];
      s_d.ctl.scaled_en   = s_d.cfg[CFG_SCALED];
      s_d.ctl.auto_en     = s_d.cfg[CFG_AUTO];
      s_d.ctl.qtab_id     = s_d.cfg[7:CFG_QID_LSB];
      s_d.ctl.restart_int = s_d.restart;
      s_d.ctl.restart_en  = (s_d.restart != 16'h0000);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q                 <= '0;
         s_q.st              <= JEC_IDLE;
         s_q.method          <= RST_METHOD;
         s_q.width           <= RST_WIDTH;
         s_q.height          <= RST_HEIGHT;
         s_q.format          <= RST_FORMAT;
         s_q.cfg             <= RST_CONFIG;
         s_q.restart         <= RST_RESTART;
         s_q.qscale[0]       <= RST_QUANT_SCALE_FIRST;
         s_q.qscale[1]       <= RST_QUANT_SCALE_SECOND;
         s_q.qscale[2]       <= RST_QUANT_SCALE_THIRD;
         s_q.wait_lim        <= RST_WAIT_LIM;
         s_q.len             <= RST_LEN;
         s_q.ctl.scaled_en   <= RST_CONFIG[CFG_SCALED];
         s_q.ctl.auto_en     <= RST_CONFIG[CFG_AUTO];
         s_q.ctl.qtab_id     <= RST_CONFIG[7:CFG_QID_LSB];
         s_q.ctl.video       <= RST_CONFIG[CFG_VIDEO];
         s_q.ctl.qscale[0]   <= RST_QUANT_SCALE_FIRST[QS_FACT_W-1:0];
         s_q.ctl.qscale[1]   <= RST_QUANT_SCALE_SECOND[QS_FACT_W-1:0];
         s_q.ctl.qscale[2]   <= RST_QUANT_SCALE_THIRD[QS_FACT_W-1:0];
      end else begin
         s_q <= s_d;
      end
   end

   assign var_rdata  = s_q.rdata;
   assign var_rvalid = s_q.rvalid;
   assign enc_ctl    = s_q.ctl;
endmodule

// [design/jec_frame_timer.sv]
// Frame counter that ends the wait for a host answer
`timescale 1ns/1ps
module jec_frame_timer
   import jec_pkg::*;
#(
   parameter int LIMIT_W = 8
) (
   input  wire logic               clk,     // System clock
   input  wire logic               rst,     // Async reset, active high
   input  wire logic               arm,     // Start counting frames
   input  wire logic               stop,    // Abandon the count
   input  wire logic               tick,    // One pulse per frame
   input  wire logic [LIMIT_W-1:0] limit,   // Frames to wait
   output logic                    expired  // One-cycle pulse at timeout
);
   initial begin
      if (LIMIT_W < 1 || LIMIT_W > 8) begin
         $error("jec_frame_timer: LIMIT_W must be 1..8");
      end
   end

   jec_tmr_t s_q;
   jec_tmr_t s_d;

   always_comb begin
      s_d         = s_q;
      s_d.expired = 1'b0;
      if (arm) begin
         s_d.active = 1'b1;
         s_d.count  = 8'h00;
      end else if (stop) begin
         s_d.active = 1'b0;
      end else if (s_q.active && tick) begin
         // A limit of zero still waits one frame boundary
         if (8'(s_q.count + 8'h01) >= 8'(limit)) begin
            s_d.active  = 1'b0;
            s_d.expired = 1'b1;
         end else begin
            s_d.count = 8'(s_q.count + 8'h01);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign expired = s_q.expired;
endmodule

// [dv/jec_ctrl_vars_monitor.sv]
// Port-level checker for the JPEG encoder control variable bank
`timescale 1ns/1ps
module jec_ctrl_vars_monitor
   import jec_pkg::*;
#(
   parameter int ADDR_W  = 5,
   parameter int LIMIT_W = 8
) (
   input wire logic              clk,          // System clock
   input wire logic              rst,          // Async reset, active high
   input wire logic [ADDR_W-1:0] var_addr,     // Variable byte offset
   input wire logic              var_wr,       // Write strobe
   input wire logic              var_rd,       // Read strobe
   input wire logic [7:0]        var_wdata,    // Write data
   input wire logic [7:0]        var_rdata,    // Read data
   input wire logic              var_rvalid,   // Read data valid
   input wire logic              capture_req,  // Snapshot request
   input wire logic              frame_tick,   // Frame boundary pulse
   input wire jec_enc_res_t      enc_res,      // Frame result
   input wire logic [15:0]       out_width,    // Output width
   input wire logic [15:0]       out_height,   // Output height
   input wire logic [1:0]        auto_qtab_id, // Auto table id
   input wire jec_enc_ctl_t      enc_ctl       // Encoder controls
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   rd_answer_a: assert property (var_rd |=> var_rvalid)
      else $error("read not answered");
   rvalid_pulse_a: assert property (!var_rd |=> !var_rvalid)
      else $error("stray read valid");
   unmapped_rd_a: assert property (var_rd && var_addr > ADDR_W'('h11) |=> var_rdata == 8'h00)
      else $error("unmapped read not zero");
   snap_start_a: assert property (capture_req && !enc_ctl.run && !enc_ctl.host_wait
      && !enc_ctl.video |=> enc_ctl.run)
      else $error("snapshot did not start");
   snap_end_a: assert property (enc_res.done && enc_res.ok && enc_ctl.run && !enc_ctl.video
      |=> !enc_ctl.run && !enc_ctl.host_wait)
      else $error("snapshot did not stop");
   hs_entry_a: assert property ($rose(enc_ctl.host_wait)
      |-> $past(enc_res.done && !enc_res.ok && enc_ctl.run))
      else $error("host wait without failed frame");
   retry_run_a: assert property (enc_ctl.retry |-> enc_ctl.run)
      else $error("retry without encode");
   restart_en_a: assert property (enc_ctl.restart_en == (enc_ctl.restart_int != 16'h0000))
      else $error("restart enable mismatch");
   qload_cause_a: assert property (|enc_ctl.qload |-> $past(frame_tick && !enc_ctl.host_wait))
      else $error("scale load without frame tick");
   fmt_refuse_a: assert property (var_wr && var_addr == ADDR_W'(OFS_FORMAT)
      && var_wdata > FMT_MONO |=> $stable(enc_ctl.format))
      else $error("bad format code accepted");
   video_write_a: assert property (var_wr && var_addr == ADDR_W'(OFS_CONFIG)
      |=> enc_ctl.video == $past(var_wdata[CFG_VIDEO]) && enc_ctl.scaled_en == $past(var_wdata[CFG_SCALED]))
      else $error("config write not applied");
   restart_write_a: assert property (var_wr && var_addr == ADDR_W'(OFS_RESTART + 5'h01)
      |=> enc_ctl.restart_int[7:0] == $past(var_wdata))
      else $error("restart interval write not applied");

   cover property ($rose(enc_ctl.host_wait));
   cover property (enc_ctl.retry);
   cover property (|enc_ctl.qload);
endmodule

bind jec_ctrl_vars jec_ctrl_vars_monitor #(.ADDR_W(ADDR_W), .LIMIT_W(LIMIT_W)) mon_i (
   .clk(clk), .rst(rst), .var_addr(var_addr), .var_wr(var_wr), .var_rd(var_rd),
   .var_wdata(var_wdata), .var_rdata(var_rdata), .var_rvalid(var_rvalid),
   .capture_req(capture_req), .frame_tick(frame_tick), .enc_res(enc_res),
   .out_width(out_width), .out_height(out_height), .auto_qtab_id(auto_qtab_id),
   .enc_ctl(enc_ctl));

// [dv/jec_ctrl_vars_test.sv]
// Self-checking testbench for the JPEG encoder control variable bank
`timescale 1ns/1ps
module jec_ctrl_vars_test;
   import jec_pkg::*;
   localparam logic [143:0] RST_IMG = 144'he453_0640_04b0_00_34_0000_06_09_0c_0a_00_00_0000;
   logic         clk, rst, var_wr, var_rd, capture_req, frame_tick, ok_cmd, var_rvalid;
   logic [4:0]   var_addr;
   logic [7:0]   var_wdata, var_rdata;
   logic [15:0]  out_width, out_height;
   logic [1:0]   auto_qtab_id;
   logic [23:0]  len_cmd;
   jec_enc_res_t enc_res;
   jec_enc_ctl_t enc_ctl;
   int           err_total, check_count, n;

   jec_ctrl_vars jec_ctrl_vars_i (.clk(clk), .rst(rst), .var_addr(var_addr), .var_wr(var_wr),
      .var_rd(var_rd), .var_wdata(var_wdata), .var_rdata(var_rdata), .var_rvalid(var_rvalid),
      .capture_req(capture_req), .frame_tick(frame_tick), .enc_res(enc_res),
      .out_width(out_width), .out_height(out_height), .auto_qtab_id(auto_qtab_id),
      .enc_ctl(enc_ctl));
   jec_enc_model jec_enc_model_i (.clk(clk), .rst(rst), .run(enc_ctl.run), .ok_cmd(ok_cmd),
      .len_cmd(len_cmd), .enc_res(enc_res));

   task test_done;
      $display("TB: %0d checks, %0d errors", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk); #1;
      var_addr = a; var_wdata = d; var_wr = 1'b1;
      @(posedge clk); #1;
      var_wr = 1'b0;
   endtask

   // Data is looked at in the single cycle that the valid pulse stands
   task rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge clk); #1;
      var_addr = a; var_rd = 1'b1;
      @(posedge clk); #1;
      var_rd = 1'b0;
      chk(var_rvalid, 1'b1);
      chk(var_rdata, exp);
   endtask

   task pulse(input bit tick);
      @(posedge clk); #1;
      if (tick) frame_tick = 1'b1;
      else capture_req = 1'b1;
      @(posedge clk); #1;
      frame_tick = 1'b0;
      capture_req = 1'b0;
   endtask

   function logic sig(input int s);
      case (s)
         0: return enc_ctl.run;
         1: return enc_ctl.host_wait;
         default: return enc_ctl.retry;
      endcase
   endfunction

   task wt(input int s, input logic v);
      n = 0;
      while (sig(s) !== v && n < 60) begin
         @(posedge clk); #1;
         n++;
      end
      if (sig(s) !== v) begin
         err_total++;
         $display("ERROR t=%0t wait expired", $time);
         test_done();
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      {rst, ok_cmd} = 2'b11;
      {var_wr, var_rd, capture_req, frame_tick} = 4'h0;
      var_addr = 5'h00; var_wdata = 8'h00; len_cmd = 24'h000000; auto_qtab_id = 2'h0;
      out_width = RST_WIDTH; out_height = RST_HEIGHT; err_total = 0; check_count = 0;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      for (int i = 0; i < 18; i++) rd(i[4:0], RST_IMG[143-8*i -: 8]);
      chk(enc_ctl.scaled_en, 1'b1);
      chk(enc_ctl.auto_en, 1'b1);
      $display("TB: reset values done");
      wr(OFS_WIDTH, 8'hff);
      out_width = 16'h0320;
      rd(OFS_WIDTH, 8'h03);
      rd(OFS_WIDTH + 5'h01, 8'h20);
      for (int f = 0; f < 4; f++) begin
         wr(OFS_FORMAT, f[7:0]);
         rd(OFS_FORMAT, f < 3 ? f[7:0] : 8'h02);
         chk(enc_ctl.format, f < 3 ? f[1:0] : 2'h2);
      end
      rd(5'h1f, 8'h00);
      wr(OFS_RESTART, 8'h01);
      wr(OFS_RESTART + 5'h01, 8'h00);
      rd(OFS_RESTART, 8'h01);
      chk(enc_ctl.restart_int, 16'h0100);
      chk(enc_ctl.restart_en, 1'b1);
      wr(OFS_RESTART, 8'h00);
      rd(OFS_RESTART, 8'h00);
      chk(enc_ctl.restart_en, 1'b0);
      $display("TB: access and fields done");
      len_cmd = 24'h123456;
      pulse(1'b0);
      wt(0, 1'b1);
      wt(0, 1'b0);
      rd(OFS_LEN_HI, 8'h12);
      rd(OFS_LEN_LO, 8'h34);
      rd(OFS_LEN_LO + 5'h01, 8'h56);
      $display("TB: snapshot done");
      // A failed frame parks the bank until the host says it is ready
      auto_qtab_id = 2'h2;
      wr(OFS_CONFIG, 8'h36);
      {ok_cmd, len_cmd} = {1'b0, 24'h0a0b0c};
      pulse(1'b0);
      wt(1, 1'b1);
      chk(enc_ctl.run, 1'b0);
      rd(OFS_STATE, 8'h02);
      rd(OFS_LEN_HI, 8'h0a);
      ok_cmd = 1'b1;
      wr(OFS_CONFIG, 8'h3e);
      wt(2, 1'b1);
      chk(enc_ctl.run, 1'b1);
      wt(0, 1'b0);
      rd(OFS_CONFIG, 8'hb6);
      rd(OFS_STATE, 8'h00);
      $display("TB: handshake and retry done");
      wr(OFS_WAIT_LIM, 8'h02);
      ok_cmd = 1'b0;
      pulse(1'b0);
      wt(1, 1'b1);
      pulse(1'b1);
      chk(enc_ctl.host_wait, 1'b1);
      ok_cmd = 1'b1;
      pulse(1'b1);
      wt(1, 1'b0);
      wt(0, 1'b0);
      $display("TB: host timeout done");
      wr(OFS_QUANT_SCALE_FIRST, 8'h95);
      rd(OFS_QUANT_SCALE_FIRST, 8'h95);
      pulse(1'b1);
      chk(enc_ctl.qload, 3'b001);
      rd(OFS_QUANT_SCALE_FIRST, 8'h15);
      chk(enc_ctl.qscale[0], 7'h15);
      chk(enc_ctl.qscale[1], 7'h09);
      $display("TB: scaling done");
      wr(OFS_CONFIG, 8'h35);
      wt(0, 1'b1);
      chk(enc_ctl.video, 1'b1);
      // Several frames must pass with encode still running
      repeat (12) @(posedge clk);
      #1 chk(enc_ctl.run, 1'b1);
      wr(OFS_CONFIG, 8'h40);
      wt(0, 1'b0);
      chk(enc_ctl.scaled_en, 1'b0);
      chk(enc_ctl.auto_en, 1'b0);
      chk(enc_ctl.qtab_id, 2'h1);
      rd(OFS_CONFIG, 8'h40);
      $display("TB: video done");
      test_done();
   end
endmodule

// [dv/jec_enc_model.sv]
// Encoder datapath stand-in: ends each frame a fixed time after it starts
`timescale 1ns/1ps
module jec_enc_model
   import jec_pkg::*;
#(
   parameter int LAT = 3
) (
   input  wire logic        clk,     // System clock
   input  wire logic        rst,     // Async reset, active high
   input  wire logic        run,     // Encode enable from the bank
   input  wire logic        ok_cmd,  // Outcome of the next frame
   input  wire logic [23:0] len_cmd, // Length of the next frame
   output jec_enc_res_t     enc_res  // Frame result
);
   int cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         enc_res <= '0;
      end else if (run && cnt == LAT) begin
         cnt <= 0;
         enc_res <= {1'b1, ok_cmd, len_cmd};
      end else begin
         cnt <= run ? cnt + 1 : 0;
         // Scramble qualifiers outside done so a stale result never looks valid
         enc_res <= {1'b0, ~enc_res.ok, ~len_cmd};
      end
   end
endmodule

// [shared/jec_pkg.sv]
// Constants and types for the JPEG encoder control variable bank
package jec_pkg;

   // Byte offsets of the driver variables; 16-bit ones span offset and offset+1
   localparam logic [4:0] OFS_METHOD   = 5'h00;
   localparam logic [4:0] OFS_WIDTH    = 5'h02;
   localparam logic [4:0] OFS_HEIGHT   = 5'h04;
   localparam logic [4:0] OFS_FORMAT   = 5'h06;
   localparam logic [4:0] OFS_CONFIG   = 5'h07;
   localparam logic [4:0] OFS_RESTART  = 5'h08;
   localparam logic [4:0] OFS_QUANT_SCALE_FIRST  = 5'h0a;
   localparam logic [4:0] OFS_QUANT_SCALE_SECOND  = 5'h0b;
   localparam logic [4:0] OFS_QUANT_SCALE_THIRD  = 5'h0c;
   localparam logic [4:0] OFS_WAIT_LIM = 5'h0d;
   localparam logic [4:0] OFS_STATE    = 5'h0e;
   localparam logic [4:0] OFS_LEN_HI   = 5'h0f;
   localparam logic [4:0] OFS_LEN_LO   = 5'h10;

   // Reset values
   localparam logic [15:0] RST_METHOD   = 16'he453;
   localparam logic [15:0] RST_WIDTH    = 16'h0640;
   localparam logic [15:0] RST_HEIGHT   = 16'h04b0;
   localparam logic [7:0]  RST_FORMAT   = 8'h00;
   localparam logic [7:0]  RST_CONFIG   = 8'h34;
   localparam logic [15:0] RST_RESTART  = 16'h0000;
   localparam logic [7:0]  RST_QUANT_SCALE_FIRST  = 8'h06;
   localparam logic [7:0]  RST_QUANT_SCALE_SECOND  = 8'h09;
   localparam logic [7:0]  RST_QUANT_SCALE_THIRD  = 8'h0c;
   localparam logic [7:0]  RST_WAIT_LIM = 8'h0a;
   localparam logic [23:0] RST_LEN      = 24'h000000;

   // Configuration byte fields
   localparam int CFG_VIDEO   = 0;
   localparam int CFG_HSHAKE  = 1;
   localparam int CFG_RETRY   = 2;
   localparam int CFG_READY   = 3;
   localparam int CFG_SCALED  = 4;
   localparam int CFG_AUTO    = 5;
   localparam int CFG_QID_LSB = 6;

   // Scaling byte fields
   localparam int QS_NEW    = 7;
   localparam int QS_FACT_W = 7;

   // Image format codes
   localparam logic [7:0] FMT_422  = 8'h00;
   localparam logic [7:0] FMT_420  = 8'h01;
   localparam logic [7:0] FMT_MONO = 8'h02;

   typedef enum logic [2:0] {
      JEC_IDLE   = 3'b000,
      JEC_ENCODE = 3'b001,
      JEC_WAIT   = 3'b010
   } jec_state_t;

   // Result of one frame from the encoder
   typedef struct packed {
      logic        done;
      logic        ok;
      logic [23:0] len;
   } jec_enc_res_t;

   // Controls towards the encoder datapath
   typedef struct packed {
      logic                      run;
      logic [1:0]                format;
      logic                      video;
      logic                      restart_en;
      logic [15:0]               restart_int;
      logic                      scaled_en;
      logic                      auto_en;
      logic [1:0]                qtab_id;
      logic [2:0][QS_FACT_W-1:0] qscale;
      logic [2:0]                qload;
      logic                      retry;
      logic                      host_wait;
   } jec_enc_ctl_t;

   // All state of the control bank
   typedef struct packed {
      jec_state_t   st;
      logic [15:0]  method;
      logic [15:0]  width;
      logic [15:0]  height;
      logic [7:0]   format;
      logic [7:0]   cfg;
      logic [15:0]  restart;
      logic [2:0][7:0] qscale;
      logic [7:0]   wait_lim;
      logic [23:0]  len;
      logic [7:0]   rdata;
      logic         rvalid;
      logic         arm;
      jec_enc_ctl_t ctl;
   } jec_regs_t;

   // All state of the frame timeout counter
   typedef struct packed {
      logic       active;
      logic [7:0] count;
      logic       expired;
   } jec_tmr_t;

endpackage
